//--- rtl/bus_hold_pkg.sv
// Operation
// - on hold request, finish any bus transaction in progress before releasing the bus
// - during hold, float address, data, access strobe and read/write lines
// - keep transactions suspended until hold request rises or ignore bit is set
// - drive bus release acknowledge in answer to a low hold request
// - stay in reset condition while the reset input is high
// - after reset release, start execution at the reset vector address
// - while shutdown is active, stop and float every pin
// - contents are kept during shutdown; the bus state returns to idle and the req_taken, done, start and interrupt acknowledge pulses go inactive
// - pulse interrupt acknowledge only when the acknowledge instruction executes
// - each pin floats under its flagged conditions: shutdown, hold, reset
// - external flag pins work as general I/O lines with per-pin direction
package bus_hold_pkg;
  localparam logic [23:0] RESET_VECTOR_ADDR = 24'h000000;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int XF_W = 2;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_XFER = 5'h02,
    ST_HELD = 5'h04,
    ST_UNACK = 5'h08,
    ST_REDRIVE = 5'h10
  } bus_state_type;
endpackage

//--- rtl/primary_bus_hold_and_pin_float.sv
`timescale 1ns/1ps
module primary_bus_hold_and_pin_float
  import bus_hold_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // pin controls
  input wire logic i_hold_req_n,
  input wire logic i_all_pins_float_n,
  input wire logic i_ignore_bus_request_bit,
  // sequencer request
  input wire logic i_req,
  input wire logic i_req_rd,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic [DATA_W-1:0] i_req_wdata,
  input wire logic i_ready_n,
  input wire logic i_ack_instr,
  input wire logic [XF_W-1:0] i_flag_out,
  input wire logic [XF_W-1:0] i_flag_dir_out,
  input wire logic [XF_W-1:0] i_ext_flag_pins,
  // sequencer answer
  output logic o_req_taken,
  output logic o_done,
  output logic [DATA_W-1:0] o_rdata,
  output logic [ADDR_W-1:0] o_start_pc,
  output logic o_start,
  output logic [XF_W-1:0] o_flag_in,
  // primary bus pins
  output logic [ADDR_W-1:0] o_addr,
  output logic o_addr_oe_n,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe_n,
  input wire logic [DATA_W-1:0] i_data,
  output logic o_access_strobe,
  output logic o_strobe_oe_n,
  output logic o_rw,
  output logic o_rw_oe_n,
  output logic o_bus_release_ack,
  output logic o_ack_oe_n,
  output logic o_int_ack_out,
  output logic o_int_ack_out_oe_n,
  output logic [XF_W-1:0] o_ext_flag_pins,
  output logic [XF_W-1:0] o_flag_oe_n
);
  typedef struct packed {
    bus_state_type st;
    logic req_taken;
    logic done;
    logic [DATA_W-1:0] rdata;
    logic [ADDR_W-1:0] start_pc;
    logic start;
    logic [XF_W-1:0] flag_in;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic data_drive;
    logic strobe;
    logic rw;
    logic bus_float;
    logic ack;
    logic int_ack_out;
    logic sd_float;
    logic [XF_W-1:0] xf;
    logic [XF_W-1:0] xf_oe_n;
    logic addr_oe_n;
    logic data_oe_n;
    logic strobe_oe_n;
    logic rw_oe_n;
    logic ack_oe_n;
    logic int_ack_out_oe_n;
    logic [XF_W-1:0] flag_oe_n;
  } state_type;
  state_type cur;
  state_type next_cur;
  logic hold_on;
  assign hold_on = !i_hold_req_n && !i_ignore_bus_request_bit;
  always_comb begin
    next_cur = cur;
    next_cur.req_taken = 1'b0;
    next_cur.done = 1'b0;
    next_cur.start = 1'b0;
    next_cur.int_ack_out = 1'b1;
    next_cur.flag_in = i_ext_flag_pins;
    next_cur.xf = i_flag_out;
    next_cur.xf_oe_n = ~i_flag_dir_out;
    next_cur.sd_float = 1'b0;
    if (i_ack_instr) begin
      next_cur.int_ack_out = 1'b0;
    end
    unique case (cur.st)
      ST_IDLE: begin
        if (hold_on) begin
          next_cur.st = ST_HELD;
          next_cur.bus_float = 1'b1;
          next_cur.ack = 1'b0;
        end else if (i_req) begin
          next_cur.st = ST_XFER;
          next_cur.req_taken = 1'b1;
          next_cur.addr = i_req_addr;
          next_cur.data = i_req_wdata;
          next_cur.rw = i_req_rd;
          next_cur.data_drive = !i_req_rd;
          next_cur.strobe = 1'b0;
        end
      end
      ST_XFER: begin
        if (!i_ready_n) begin
          next_cur.st = ST_IDLE;
          next_cur.done = 1'b1;
          next_cur.rdata = i_data;
          next_cur.strobe = 1'b1;
          next_cur.data_drive = 1'b0;
          next_cur.rw = 1'b1;
        end
      end
      ST_HELD: begin
        if (!hold_on) begin
          next_cur.st = ST_UNACK;
          next_cur.ack = 1'b1;
        end
      end
      ST_UNACK: begin
        next_cur.st = ST_REDRIVE;
        next_cur.bus_float = 1'b0;
      end
      ST_REDRIVE: begin
        next_cur.st = ST_IDLE;
      end
    endcase
    if (!i_all_pins_float_n) begin
      next_cur = cur;
      next_cur.st = ST_IDLE;
      next_cur.sd_float = 1'b1;
      next_cur.int_ack_out = 1'b1;
      next_cur.req_taken = 1'b0;
      next_cur.done = 1'b0;
      next_cur.start = 1'b0;
      next_cur.flag_in = cur.flag_in;
    end
    next_cur.addr_oe_n = next_cur.bus_float | next_cur.sd_float;
    next_cur.data_oe_n = next_cur.bus_float | next_cur.sd_float | !next_cur.data_drive;
    next_cur.strobe_oe_n = next_cur.bus_float | next_cur.sd_float;
    next_cur.rw_oe_n = next_cur.bus_float | next_cur.sd_float;
    next_cur.ack_oe_n = next_cur.sd_float;
    next_cur.int_ack_out_oe_n = next_cur.sd_float;
    next_cur.flag_oe_n = next_cur.xf_oe_n | {XF_W{next_cur.sd_float}};
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cur <= '0;
      cur.st <= ST_IDLE;
      cur.start_pc <= RESET_VECTOR_ADDR;
      cur.start <= 1'b1;
      cur.strobe <= 1'b1;
      cur.rw <= 1'b1;
      cur.ack <= 1'b1;
      cur.int_ack_out <= 1'b1;
      cur.xf_oe_n <= {XF_W{1'b1}};
      cur.addr_oe_n <= 1'b1;
      cur.data_oe_n <= 1'b1;
      cur.strobe_oe_n <= 1'b0;
      cur.rw_oe_n <= 1'b1;
      cur.ack_oe_n <= 1'b1;
      cur.int_ack_out_oe_n <= 1'b0;
      cur.flag_oe_n <= {XF_W{1'b1}};
    end else begin
      cur <= next_cur;
    end
  end
  assign o_req_taken = cur.req_taken;
  assign o_done = cur.done;
  assign o_rdata = cur.rdata;
  assign o_start_pc = cur.start_pc;
  assign o_start = cur.start;
  assign o_flag_in = cur.flag_in;
  assign o_addr = cur.addr;
  assign o_addr_oe_n = cur.addr_oe_n;
  assign o_data = cur.data;
  assign o_data_oe_n = cur.data_oe_n;
  assign o_access_strobe = cur.strobe;
  assign o_strobe_oe_n = cur.strobe_oe_n;
  assign o_rw = cur.rw;
  assign o_rw_oe_n = cur.rw_oe_n;
  assign o_bus_release_ack = cur.ack;
  assign o_ack_oe_n = cur.ack_oe_n;
  assign o_int_ack_out = cur.int_ack_out;
  assign o_int_ack_out_oe_n = cur.int_ack_out_oe_n;
  assign o_ext_flag_pins = cur.xf;
  assign o_flag_oe_n = cur.flag_oe_n;
  a_hold_after_xfer: assert property (@(posedge i_clk) disable iff (i_reset)
    (cur.st == ST_XFER && i_ready_n && i_all_pins_float_n) |=> !cur.bus_float)
    else $error("bus released mid transfer");
  a_hold_floats: assert property (@(posedge i_clk) disable iff (i_reset)
    (cur.st == ST_HELD) |-> (o_addr_oe_n && o_data_oe_n && o_strobe_oe_n && o_rw_oe_n))
    else $error("bus driven during hold");
  a_hold_no_take: assert property (@(posedge i_clk) disable iff (i_reset)
    (cur.st == ST_HELD && hold_on) |=> !o_req_taken)
    else $error("transaction taken during hold");
  a_ack_on_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    (cur.st == ST_IDLE && hold_on && i_all_pins_float_n) |=> !o_bus_release_ack)
    else $error("no acknowledge on hold");
  a_reset_start: assert property (@(posedge i_clk)
    i_reset |=> (o_start && o_start_pc == RESET_VECTOR_ADDR))
    else $error("no start at reset vector");
  a_shutdown_float: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_all_pins_float_n |=> (o_addr_oe_n && o_ack_oe_n && o_int_ack_out_oe_n && &o_flag_oe_n))
    else $error("pin driven in shutdown");
  a_int_ack_out_cause: assert property (@(posedge i_clk) disable iff (i_reset)
    !o_int_ack_out |-> $past(i_ack_instr))
    else $error("stray interrupt acknowledge");
  a_release_order: assert property (@(posedge i_clk) disable iff (i_reset)
    (cur.st == ST_HELD && !hold_on && i_all_pins_float_n) |=>
    (o_bus_release_ack && o_addr_oe_n) ##1 !cur.bus_float)
    else $error("bad release order");
  a_reset_float: assert property (@(posedge i_clk)
    i_reset |=> (o_addr_oe_n && o_data_oe_n && o_rw_oe_n && &o_flag_oe_n &&
    !o_strobe_oe_n && !o_int_ack_out_oe_n))
    else $error("wrong pin float in reset");
  a_flag_dir: assert property (@(posedge i_clk) disable iff (i_reset)
    i_all_pins_float_n |=> (o_flag_oe_n == ~$past(i_flag_dir_out)))
    else $error("flag direction not followed");
  c_hold: cover property (@(posedge i_clk) cur.st == ST_HELD ##1 cur.st == ST_UNACK);
  c_xfer: cover property (@(posedge i_clk) o_req_taken ##[1:5] o_done);
  c_sd: cover property (@(posedge i_clk) !i_all_pins_float_n);
  c_write: cover property (@(posedge i_clk) o_req_taken && !o_rw);
  c_redrive: cover property (@(posedge i_clk) cur.st == ST_REDRIVE ##1 cur.st == ST_IDLE);
endmodule

//--- tb/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
  // clock and commands
  input wire logic i_clk,
  input wire logic i_take_bus,
  input wire logic [3:0] i_wait,
  // bus side
  input wire logic i_access_strobe,
  input wire logic [23:0] i_addr,
  input wire logic i_rw,
  input wire logic [31:0] i_wdata,
  output logic o_hold_req_n,
  output logic o_ready_n,
  output logic [31:0] o_data
);
  logic [3:0] cnt = 4'h0;
  initial begin
    o_hold_req_n = 1'b1;
    o_ready_n = 1'b1;
    o_data = 32'h0;
  end
  // read data follows the address, write data is echoed; a released bus toggles every cycle
  always @(posedge i_clk) begin
    o_hold_req_n <= ~i_take_bus;
    o_data <= i_access_strobe ? ~o_data : (i_rw ? {8'hA5, i_addr} : i_wdata);
    cnt <= i_access_strobe ? 4'h0 : cnt + 4'h1;
    o_ready_n <= !(!i_access_strobe && cnt >= i_wait);
  end
endmodule

//--- tb/primary_bus_hold_and_pin_float_tb.sv
`timescale 1ns/1ps
module primary_bus_hold_and_pin_float_tb;
  import bus_hold_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_all_pins_float_n = 1'b1;
  logic i_ignore_bus_request_bit = 1'b0;
  logic i_req = 1'b0;
  logic i_req_rd = 1'b1;
  logic i_ack_instr = 1'b0;
  logic take = 1'b0;
  logic [3:0] wt = 4'h0;
  logic [ADDR_W-1:0] i_req_addr = 24'h0;
  logic [DATA_W-1:0] i_req_wdata = 32'h0;
  logic [XF_W-1:0] i_flag_out = 2'h1;
  logic [XF_W-1:0] i_flag_dir_out = 2'h3;
  logic [XF_W-1:0] i_ext_flag_pins = 2'h2;
  logic i_hold_req_n, i_ready_n, o_req_taken, o_done, o_start, o_addr_oe_n, o_data_oe_n;
  logic o_access_strobe, o_strobe_oe_n, o_rw, o_rw_oe_n, o_bus_release_ack, o_ack_oe_n;
  logic o_int_ack_out, o_int_ack_out_oe_n;
  logic [DATA_W-1:0] i_data, o_rdata, o_data;
  logic [ADDR_W-1:0] o_start_pc, o_addr;
  logic [XF_W-1:0] o_flag_in, o_ext_flag_pins, o_flag_oe_n;
  logic [31:0] q[$];
  int fail_count = 0;
  int n_checks = 0;
  int k, iacks = 0, cyc = 0;
  primary_bus_hold_and_pin_float dut (.i_clk, .i_reset, .i_hold_req_n, .i_all_pins_float_n,
    .i_ignore_bus_request_bit, .i_req, .i_req_rd, .i_req_addr, .i_req_wdata, .i_ready_n,
    .i_ack_instr, .i_flag_out, .i_flag_dir_out, .i_ext_flag_pins, .o_req_taken, .o_done,
    .o_rdata, .o_start_pc, .o_start, .o_flag_in, .o_addr, .o_addr_oe_n, .o_data, .o_data_oe_n,
    .i_data, .o_access_strobe, .o_strobe_oe_n, .o_rw, .o_rw_oe_n, .o_bus_release_ack,
    .o_ack_oe_n, .o_int_ack_out, .o_int_ack_out_oe_n, .o_ext_flag_pins, .o_flag_oe_n);
  bus_master_model far (.i_clk, .i_take_bus(take), .i_wait(wt), .i_access_strobe(o_access_strobe),
    .i_addr(o_addr), .i_rw(o_rw), .i_wdata(o_data), .o_hold_req_n(i_hold_req_n),
    .o_ready_n(i_ready_n), .o_data(i_data));
  initial forever #50 i_clk = ~i_clk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %0t: got %h want %h", $time, s, e);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task tk;
    @(posedge i_clk);
    #1;
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic r, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    i_req <= 1'b1;
    i_req_rd <= r;
    i_req_addr <= a;
    i_req_wdata <= d;
    q.push_back(r ? {8'hA5, a} : d);
    k = 0;
    do begin tk(); k++; end while (o_req_taken !== 1'b1 && k < 30);
    chk({o_req_taken, o_access_strobe, o_rw, o_data_oe_n, o_addr}, {1'b1, 1'b0, r, r, a});
    if (!r) chk(o_data, d);
    @(posedge i_clk);
    i_req <= 1'b0;
    #1;
    k = 0;
    while (o_done !== 1'b1 && k < 30) begin tk(); k++; end
    chk({o_done, o_access_strobe, o_rw, o_data_oe_n}, 4'hF);
  endtask
  task no_take;
    @(posedge i_clk);
    i_req <= 1'b1;
    k = 0;
    repeat (6) begin tk(); if (o_req_taken !== 1'b0) k++; end
    @(posedge i_clk);
    i_req <= 1'b0;
    chk(k, 0);
  endtask
  task rst;
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (20) tk();
    chk({o_addr_oe_n, o_data_oe_n, o_strobe_oe_n, o_rw_oe_n, o_int_ack_out_oe_n, o_flag_oe_n},
      7'h6B);
    @(posedge i_clk);
    i_reset <= 1'b0;
    #1;
    chk({o_start, o_start_pc}, {1'b1, RESET_VECTOR_ADDR});
    tk();
    chk(o_start, 1'b0);
  endtask
  // results monitor and pulse counter
  always @(negedge i_clk) begin
    if (o_done === 1'b1) begin
      if (q.size() == 0) chk(o_done, 1'b0);
      else chk(o_rdata, q.pop_front());
    end
    if (o_int_ack_out === 1'b0) iacks++;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin fail_count++; end_of_test(); end
  end
  initial begin
    void'($urandom(32'hB55EFD46));
    rst();
    chk({o_ext_flag_pins, o_flag_oe_n}, 4'h4);
    rd(ADDR_W'($urandom), 1'b0, $urandom);
    rd(ADDR_W'($urandom), 1'b1, 32'h0);
    @(posedge i_clk);
    take <= 1'b1;
    repeat (3) tk();
    chk({o_bus_release_ack, o_addr_oe_n, o_data_oe_n, o_strobe_oe_n, o_rw_oe_n}, 5'h0F);
    no_take();
    @(posedge i_clk);
    take <= 1'b0;
    k = 0;
    do begin tk(); k++; end while (o_bus_release_ack !== 1'b1 && k < 10);
    chk(o_addr_oe_n, 1'b1);
    tk();
    chk(o_addr_oe_n, 1'b0);
    @(posedge i_clk);
    wt <= 4'h4;
    fork
      rd(ADDR_W'($urandom), 1'b1, 32'h0);
      begin repeat (2) @(posedge i_clk); take <= 1'b1; end
    join
    chk(o_bus_release_ack, 1'b1);
    repeat (3) tk();
    chk(o_bus_release_ack, 1'b0);
    @(posedge i_clk);
    i_ignore_bus_request_bit <= 1'b1;
    rd(ADDR_W'($urandom), 1'b1, 32'h0);
    @(posedge i_clk);
    take <= 1'b0;
    i_ignore_bus_request_bit <= 1'b0;
    i_flag_dir_out <= 2'h0;
    i_all_pins_float_n <= 1'b0;
    repeat (3) tk();
    chk({o_addr_oe_n, o_data_oe_n, o_strobe_oe_n, o_rw_oe_n, o_ack_oe_n, o_int_ack_out_oe_n,
      o_flag_oe_n}, 8'hFF);
    no_take();
    @(posedge i_clk);
    i_all_pins_float_n <= 1'b1;
    rst();
    chk({o_flag_in, o_flag_oe_n}, 4'hB);
    chk(iacks, 0);
    @(posedge i_clk);
    i_ack_instr <= 1'b1;
    @(posedge i_clk);
    i_ack_instr <= 1'b0;
    repeat (4) tk();
    chk(iacks, 1);
    chk(q.size(), 0);
    end_of_test();
  end
endmodule
